// File: rtl/pcf_pkg.sv
package pcf_pkg;

  // Register byte offsets
  localparam logic [3:0] PCF_CTRL_OFFS   = 4'h0;
  localparam logic [3:0] PCF_STATUS_OFFS = 4'h4;

  // Control field positions
  localparam int PCF_CTRL_DRIVE_N_BIT = 0;
  localparam int PCF_CTRL_SEL_BIT     = 1;
  localparam int PCF_CTRL_BYPASS_BIT  = 2;
  localparam int PCF_CTRL_CLEAR_BIT   = 3;

  // Status field positions
  localparam int PCF_STAT_LOCKED_BIT  = 0;
  localparam int PCF_STAT_REF_OK_BIT  = 1;
  localparam int PCF_STAT_SETTLE_BIT  = 2;

  // Reset values: outputs parked in high impedance, normal loop path
  localparam logic [3:0] PCF_CTRL_RESET = 4'h1;

  // Timing
  localparam int PCF_CLK_MHZ       = 250;
  localparam int PCF_STAB_TIME_US  = 50;
  localparam int PCF_STAB_CYCLES   = PCF_STAB_TIME_US * PCF_CLK_MHZ;
  localparam int PCF_VCO_DIV       = 2;
  localparam int PCF_REF_LOSS_CYC  = 64;

  // AXI response codes
  localparam logic [1:0] PCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic clear;
    logic bypass;
    logic sel;
    logic drive_n;
  } pcf_ctrl_t;

  typedef enum logic [1:0] {
    PCF_ST_WAIT_REF = 2'h0,
    PCF_ST_SETTLE   = 2'h1,
    PCF_ST_LOCKED   = 2'h3
  } pcf_lock_t;

endpackage

// File: rtl/pcf_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pcf_pin_sync
  import pcf_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output var  logic o_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Three stages; a change counts only once the last two agree
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        o_level <= s3_reg;
    end
  end

endmodule
`default_nettype wire

// File: rtl/pcf_tick_div.sv
`timescale 1ns/1ns
`default_nettype none
module pcf_tick_div
  import pcf_pkg::*;
#(
  parameter int DIV = PCF_VCO_DIV
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  output var  logic o_tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  // One-cycle enable every DIV cycles stands in for the oscillator edge
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      o_tick  <= 1'b0;
    end
    else
    begin
      cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
      o_tick  <= (cnt_reg == LAST);
    end
  end

endmodule
`default_nettype wire

// File: rtl/pcf_clock_fanout.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pcf_clock_fanout
  import pcf_pkg::*;
#(
  parameter int STAB_CYCLES = PCF_STAB_CYCLES,
  parameter int VCO_DIV     = PCF_VCO_DIV,
  parameter int BANK_W      = 3
)
(
  input  wire logic              I_REF_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic              I_REFERENCE_CLOCK_IN,
  input  wire logic              I_LOOP_FEEDBACK_IN,
  input  wire logic [3:0]        I_S_AXI_AWADDR,
  input  wire logic              I_S_AXI_AWVALID,
  output var  logic              O_S_AXI_AWREADY,
  input  wire logic [31:0]       I_S_AXI_WDATA,
  input  wire logic [3:0]        I_S_AXI_WSTRB,
  input  wire logic              I_S_AXI_WVALID,
  output var  logic              O_S_AXI_WREADY,
  output var  logic [1:0]        O_S_AXI_BRESP,
  output var  logic              O_S_AXI_BVALID,
  input  wire logic              I_S_AXI_BREADY,
  input  wire logic [3:0]        I_S_AXI_ARADDR,
  input  wire logic              I_S_AXI_ARVALID,
  output var  logic              O_S_AXI_ARREADY,
  output var  logic [31:0]       O_S_AXI_RDATA,
  output var  logic [1:0]        O_S_AXI_RRESP,
  output var  logic              O_S_AXI_RVALID,
  input  wire logic              I_S_AXI_RREADY,
  output var  logic [BANK_W-1:0] O_BANK_ONE_OUTPUTS,
  output var  logic [BANK_W-1:0] O_BANK_ONE_OE_N,
  output var  logic [BANK_W-1:0] O_BANK_TWO_OUTPUTS,
  output var  logic [BANK_W-1:0] O_BANK_TWO_OE_N
);

  localparam int SW = $clog2(STAB_CYCLES + 1);
  localparam logic [SW-1:0] STAB_LAST = SW'(STAB_CYCLES - 1);
  localparam int LW = $clog2(PCF_REF_LOSS_CYC + 1);
  localparam logic [LW-1:0] LOSS_LAST = LW'(PCF_REF_LOSS_CYC - 1);

  pcf_ctrl_t     ctrl_reg;
  pcf_lock_t     state_reg;
  pcf_lock_t     state_next;
  logic [SW-1:0] settle_reg;
  logic [LW-1:0] loss_reg;
  logic [1:0]    div_reg;
  logic          slip_reg;
  logic          ref_lvl;
  logic          ref_d_reg;
  logic          fb_lvl;
  logic          fb_d_reg;
  logic          vco_tick;
  logic          drive_d_reg;
  logic          sel_d_reg;
  logic          bypass_d_reg;
  logic          aw_held_reg;
  logic          w_held_reg;
  logic [3:0]    aw_addr_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;

  // Pin inputs cross into the system clock domain
  pcf_pin_sync u_ref_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_pin   (I_REFERENCE_CLOCK_IN),
    .o_level (ref_lvl)
  );

  pcf_pin_sync u_fb_sync (
    .i_clk   (I_REF_CLK),
    .i_rst   (I_SYS_RST),
    .i_pin   (I_LOOP_FEEDBACK_IN),
    .o_level (fb_lvl)
  );

  // Oscillator stand-in; real frequency comes from VCO_DIV
  pcf_tick_div #(
    .DIV (VCO_DIV)
  ) u_vco (
    .i_clk  (I_REF_CLK),
    .i_rst  (I_SYS_RST),
    .o_tick (vco_tick)
  );

  // Edge detection and source selection
  wire ref_rise  = ref_lvl & ~ref_d_reg;
  wire fb_rise   = fb_lvl & ~fb_d_reg;
  wire loop_tick = vco_tick & ~slip_reg;
  wire src_tick  = ctrl_reg.bypass ? ref_rise : loop_tick;
  wire clear_hit = ctrl_reg.bypass & ctrl_reg.clear;
  wire ref_ok    = (state_reg != PCF_ST_WAIT_REF);

  // Events that break the loop and force a fresh settle
  wire drive_fall  = drive_d_reg & ~ctrl_reg.drive_n;
  wire sel_chg     = sel_d_reg ^ ctrl_reg.sel;
  wire loop_resume = bypass_d_reg & ~ctrl_reg.bypass;
  wire restart     = drive_fall | sel_chg | loop_resume;
  wire ref_lost    = (loss_reg == LOSS_LAST);

  // Bank selection: bit 0 is half rate, bit 1 quarter rate
  wire half_rate   = div_reg[0];
  wire quart_rate  = div_reg[1];
  wire bank_one_in = ctrl_reg.sel ? quart_rate : half_rate;

  // Edge history and event delays
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      ref_d_reg    <= 1'b0;
      fb_d_reg     <= 1'b0;
      drive_d_reg  <= PCF_CTRL_RESET[PCF_CTRL_DRIVE_N_BIT];
      sel_d_reg    <= PCF_CTRL_RESET[PCF_CTRL_SEL_BIT];
      bypass_d_reg <= PCF_CTRL_RESET[PCF_CTRL_BYPASS_BIT];
    end
    else
    begin
      ref_d_reg    <= ref_lvl;
      fb_d_reg     <= fb_lvl;
      drive_d_reg  <= ctrl_reg.drive_n;
      sel_d_reg    <= ctrl_reg.sel;
      bypass_d_reg <= ctrl_reg.bypass;
    end
  end

  // Counter toggles once per source edge, so each bit has 50% duty
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      div_reg <= 2'h0;
    else if (clear_hit)
      div_reg <= 2'h0;
    else if (src_tick)
      div_reg <= div_reg + 2'h1;
  end

  // Phase slip: drop one oscillator edge while feedback trails
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      slip_reg <= 1'b0;
    else if (!ctrl_reg.bypass && ref_rise && !fb_rise && state_reg != PCF_ST_LOCKED)
      slip_reg <= 1'b1;
    else if (vco_tick)
      slip_reg <= 1'b0;
  end

  // Reference presence watchdog
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      loss_reg <= '0;
    else if (ref_rise)
      loss_reg <= '0;
    else if (!ref_lost)
      loss_reg <= loss_reg + 1'b1;
  end

  // Lock sequencing; settling counts up through a bounded interval
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PCF_ST_WAIT_REF:
        if (ref_rise)
          state_next = PCF_ST_SETTLE;
      PCF_ST_SETTLE:
        if (ref_lost)
          state_next = PCF_ST_WAIT_REF;
        else if (!restart && settle_reg == STAB_LAST)
          state_next = PCF_ST_LOCKED;
      PCF_ST_LOCKED:
        if (ref_lost)
          state_next = PCF_ST_WAIT_REF;
        else if (restart)
          state_next = PCF_ST_SETTLE;
      default:
        state_next = PCF_ST_WAIT_REF;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      state_reg  <= PCF_ST_WAIT_REF;
      settle_reg <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      settle_reg <= (state_next == PCF_ST_SETTLE && state_reg == PCF_ST_SETTLE && !restart)
                    ? settle_reg + 1'b1 : '0;
    end
  end

  // Output pins: registered level and active-low enable
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_BANK_ONE_OUTPUTS <= '0;
      O_BANK_TWO_OUTPUTS <= '0;
      O_BANK_ONE_OE_N    <= '1;
      O_BANK_TWO_OE_N    <= '1;
    end
    else
    begin
      O_BANK_ONE_OUTPUTS <= {BANK_W{bank_one_in}};
      O_BANK_TWO_OUTPUTS <= {BANK_W{half_rate}};
      O_BANK_ONE_OE_N    <= {BANK_W{ctrl_reg.drive_n}};
      O_BANK_TWO_OE_N    <= {BANK_W{ctrl_reg.drive_n}};
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  wire wr_go     = aw_held_reg & w_held_reg & ~O_S_AXI_BVALID;
  wire wr_ctrl   = (aw_addr_reg == PCF_CTRL_OFFS);
  wire wr_map_ok = wr_ctrl | (aw_addr_reg == PCF_STATUS_OFFS);
  wire aw_take   = I_S_AXI_AWVALID & O_S_AXI_AWREADY;
  wire w_take    = I_S_AXI_WVALID & O_S_AXI_WREADY;

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      aw_addr_reg     <= '0;
      w_data_reg      <= '0;
      w_strb_reg      <= '0;
      O_S_AXI_AWREADY <= 1'b1;
      O_S_AXI_WREADY  <= 1'b1;
      O_S_AXI_BVALID  <= 1'b0;
      O_S_AXI_BRESP   <= PCF_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_reg     <= 1'b1;
        aw_addr_reg     <= {I_S_AXI_AWADDR[3:2], 2'h0};
        O_S_AXI_AWREADY <= 1'b0;
      end
      if (w_take)
      begin
        w_held_reg     <= 1'b1;
        w_data_reg     <= I_S_AXI_WDATA;
        w_strb_reg     <= I_S_AXI_WSTRB;
        O_S_AXI_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        O_S_AXI_BVALID <= 1'b1;
        O_S_AXI_BRESP  <= wr_map_ok ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
      end
      else if (O_S_AXI_BVALID && I_S_AXI_BREADY)
      begin
        O_S_AXI_BVALID  <= 1'b0;
        O_S_AXI_AWREADY <= 1'b1;
        O_S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Control register; status is read-only so writes to it are dropped
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      ctrl_reg <= pcf_ctrl_t'(PCF_CTRL_RESET);
    else if (wr_go && wr_ctrl && w_strb_reg[0])
      ctrl_reg <= pcf_ctrl_t'(w_data_reg[3:0]);
  end

  // AXI4-Lite read side: one read at a time, answer one cycle later
  wire [3:0]  rd_addr   = {I_S_AXI_ARADDR[3:2], 2'h0};
  wire        rd_ctrl   = (rd_addr == PCF_CTRL_OFFS);
  wire        rd_stat   = (rd_addr == PCF_STATUS_OFFS);
  wire [31:0] stat_word = {29'h0, state_reg == PCF_ST_SETTLE, ref_ok,
                           state_reg == PCF_ST_LOCKED};
  wire [31:0] rd_word   = rd_ctrl ? {28'h0, ctrl_reg} : (rd_stat ? stat_word : 32'h0);

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_S_AXI_ARREADY <= 1'b1;
      O_S_AXI_RVALID  <= 1'b0;
      O_S_AXI_RDATA   <= '0;
      O_S_AXI_RRESP   <= PCF_RESP_OKAY;
    end
    else if (I_S_AXI_ARVALID && O_S_AXI_ARREADY)
    begin
      O_S_AXI_ARREADY <= 1'b0;
      O_S_AXI_RVALID  <= 1'b1;
      O_S_AXI_RDATA   <= rd_word;
      O_S_AXI_RRESP   <= (rd_ctrl | rd_stat) ? PCF_RESP_OKAY : PCF_RESP_SLVERR;
    end
    else if (O_S_AXI_RVALID && I_S_AXI_RREADY)
    begin
      O_S_AXI_RVALID  <= 1'b0;
      O_S_AXI_ARREADY <= 1'b1;
    end
  end

  // Checks
  property p_drive_off;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    ctrl_reg.drive_n |=> (O_BANK_ONE_OE_N == '1) && (O_BANK_TWO_OE_N == '1);
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("outputs driven while drive enable is high");

  property p_drive_on;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    !ctrl_reg.drive_n |=> (O_BANK_ONE_OE_N == '0) && (O_BANK_TWO_OE_N == '0);
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("outputs floating while drive enable is low");

  property p_enable_unlocks;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (drive_fall && state_reg == PCF_ST_LOCKED && !ref_lost) |=> state_reg == PCF_ST_SETTLE;
  endproperty
  a_enable_unlocks: assert property (p_enable_unlocks)
    else $error("lock kept after drive enable fell");

  property p_loop_path;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!ctrl_reg.bypass && !clear_hit && !vco_tick) |=> div_reg == $past(div_reg);
  endproperty
  a_loop_path: assert property (p_loop_path)
    else $error("outputs moved without an oscillator edge");

  property p_bypass_path;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (ctrl_reg.bypass && !ctrl_reg.clear && ref_rise) |=> div_reg == $past(div_reg) + 2'h1;
  endproperty
  a_bypass_path: assert property (p_bypass_path)
    else $error("bypass did not follow the reference edge");

  property p_bank_one;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    ctrl_reg.sel ##1 ctrl_reg.sel |-> O_BANK_ONE_OUTPUTS == {BANK_W{$past(div_reg[1])}};
  endproperty
  a_bank_one: assert property (p_bank_one)
    else $error("bank one not at quarter rate");

  property p_bank_two;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    1'b1 |=> O_BANK_TWO_OUTPUTS == {BANK_W{$past(div_reg[0])}};
  endproperty
  a_bank_two: assert property (p_bank_two)
    else $error("bank two not at half rate");

  property p_duty;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (src_tick && !clear_hit) |=> div_reg[0] != $past(div_reg[0]);
  endproperty
  a_duty: assert property (p_duty)
    else $error("half-rate bit missed a toggle");

  property p_slip;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!ctrl_reg.bypass && ref_rise && !fb_rise && state_reg != PCF_ST_LOCKED)
      |=> slip_reg;
  endproperty
  a_slip: assert property (p_slip)
    else $error("phase slip not raised on trailing feedback");

  property p_lock_after_settle;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    $rose(state_reg == PCF_ST_LOCKED) |-> $past(settle_reg) == STAB_LAST;
  endproperty
  a_lock_after_settle: assert property (p_lock_after_settle)
    else $error("lock reported before settling finished");

  property p_settle_bound;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    state_reg == PCF_ST_SETTLE |-> settle_reg <= STAB_LAST;
  endproperty
  a_settle_bound: assert property (p_settle_bound)
    else $error("settling exceeded its interval");

  property p_clear_normal;
    @(posedge I_REF_CLK) disable iff (I_SYS_RST)
    (!ctrl_reg.bypass && ctrl_reg.clear && loop_tick) |=> div_reg == $past(div_reg) + 2'h1;
  endproperty
  a_clear_normal: assert property (p_clear_normal)
    else $error("test clear acted in normal mode");

endmodule
`default_nettype wire

// File: tb/pcf_ref_model.sv
`timescale 1ns/1ns
`default_nettype none
module pcf_ref_model
  import pcf_pkg::*;
#(
  parameter int HI_NS = 16,
  parameter int LO_NS = 24
)
(
  input  wire logic i_clk,
  input  wire logic i_run,
  input  wire logic i_fb_out,
  input  wire logic i_fb_oe_n,
  output var  logic o_ref,
  output wire logic o_fb
);
  logic float_reg = 1'b0;

  // Fixed period and phase, 40% duty; stands low while stopped
  initial
  begin
    o_ref = 1'b0;
    #1;
    forever
    begin
      o_ref = i_run;
      #HI_NS;
      o_ref = 1'b0;
      #LO_NS;
    end
  end

  // A released wire has no stable level, so show a changing pattern
  always @(posedge i_clk)
    float_reg <= ~float_reg;

  // Feedback hard-wired to one bank two pin; the changing pattern stands in while it floats
  assign o_fb = i_fb_oe_n ? float_reg : i_fb_out;
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import pcf_pkg::*;
;
  localparam int STAB     = 20;
  localparam int VDIV     = 2;
  localparam int REF_CLKS = 10;

  logic        clk = 1'b0, rst = 1'b1, ref_run = 1'b1, ref_pin;
  wire         fb_pin;
  logic [3:0]  aw_addr = 4'h0, ar_addr = 4'h0, w_strb = 4'h0;
  logic [31:0] w_data = 32'h0, r_data, rd;
  logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0;
  logic        r_ready = 1'b0, aw_ready, w_ready, b_valid, ar_ready, r_valid, sel;
  logic [1:0]  b_resp, r_resp, rs;
  logic [2:0]  b1, b1_oe_n, b2, b2_oe_n;
  int          fail_count = 0, n_tests = 0, cyc = 0, hi, lo, el;

  always #2 clk = ~clk;

  // Free cycle count for latency and period measurement
  always @(posedge clk)
    cyc <= cyc + 1;

  pcf_clock_fanout #(.STAB_CYCLES(STAB), .VCO_DIV(VDIV), .BANK_W(3)) uut (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_REFERENCE_CLOCK_IN(ref_pin),
    .I_LOOP_FEEDBACK_IN(fb_pin), .I_S_AXI_AWADDR(aw_addr), .I_S_AXI_AWVALID(aw_valid),
    .O_S_AXI_AWREADY(aw_ready), .I_S_AXI_WDATA(w_data), .I_S_AXI_WSTRB(w_strb),
    .I_S_AXI_WVALID(w_valid), .O_S_AXI_WREADY(w_ready), .O_S_AXI_BRESP(b_resp),
    .O_S_AXI_BVALID(b_valid), .I_S_AXI_BREADY(b_ready), .I_S_AXI_ARADDR(ar_addr),
    .I_S_AXI_ARVALID(ar_valid), .O_S_AXI_ARREADY(ar_ready), .O_S_AXI_RDATA(r_data),
    .O_S_AXI_RRESP(r_resp), .O_S_AXI_RVALID(r_valid), .I_S_AXI_RREADY(r_ready),
    .O_BANK_ONE_OUTPUTS(b1), .O_BANK_ONE_OE_N(b1_oe_n),
    .O_BANK_TWO_OUTPUTS(b2), .O_BANK_TWO_OE_N(b2_oe_n));

  pcf_ref_model #(.HI_NS(16), .LO_NS(24)) ref_src (
    .i_clk(clk), .i_run(ref_run), .i_fb_out(b2[0]), .i_fb_oe_n(b2_oe_n[0]),
    .o_ref(ref_pin), .o_fb(fb_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Offer address and data together, release each when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    int t;
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (t = 0; t < 200; t++)
    begin
      @(posedge clk);
      if (aw_valid && aw_ready)
        aw_valid <= 1'b0;
      if (w_valid && w_ready)
        w_valid <= 1'b0;
      if (b_valid)
      begin
        rs = b_resp;
        b_ready <= 1'b0;
        break;
      end
    end
    if (t == 200)
      fail_count++;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    int t;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (t = 0; t < 200; t++)
    begin
      @(posedge clk);
      if (ar_valid && ar_ready)
        ar_valid <= 1'b0;
      if (r_valid)
      begin
        rd = r_data;
        rs = r_resp;
        r_ready <= 1'b0;
        break;
      end
    end
    if (t == 200)
      fail_count++;
    @(posedge clk);
  endtask

  // Upper data bits and upper strobes are random; only data bits 3:0 and strobe 0 count
  task automatic set_ctrl(input logic [3:0] c);
    logic [31:0] w;
    w = $urandom();
    axi_wr(PCF_CTRL_OFFS, {w[31:4], c}, {w[3:1], 1'b1});
    check(32'(rs), 32'(PCF_RESP_OKAY));
  endtask

  task automatic wait_lock();
    int t0;
    t0 = cyc;
    rd = 32'h0;
    while (rd[PCF_STAT_LOCKED_BIT] !== 1'b1 && cyc - t0 < 200)
      axi_rd(PCF_STATUS_OFFS);
    check(32'(cyc - t0 <= STAB + 4 * REF_CLKS), 32'h1);
    check(rd, 32'h3);
  endtask

  function automatic logic [2:0] bank(input bit two);
    return two ? b2 : b1;
  endfunction

  // Pin 0 of a bank; a call result cannot be bit-selected directly
  function automatic logic pin0(input bit two);
    return two ? b2[0] : b1[0];
  endfunction

  // Half-period in clocks: one source edge, doubled on a quarter-rate bank
  function automatic int exp_half(input bit byp, input bit s, input bit two);
    int base;
    base = byp ? REF_CLKS : VDIV;
    return (!two && s) ? 2 * base : base;
  endfunction

  // High and low time of pin 0 of a bank, from one rising edge on
  task automatic measure(input bit two);
    int t0;
    t0 = cyc;
    while (pin0(two) !== 1'b0 && cyc - t0 < 50)
      @(posedge clk);
    while (pin0(two) !== 1'b1 && cyc - t0 < 100)
      @(posedge clk);
    t0 = cyc;
    while (pin0(two) === 1'b1 && cyc - t0 < 50)
      @(posedge clk);
    hi = cyc - t0;
    t0 = cyc;
    while (pin0(two) === 1'b0 && cyc - t0 < 50)
      @(posedge clk);
    lo = cyc - t0;
    check(32'(bank(two)), 32'h7);
  endtask

  initial
  begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'h8ec98395));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'({b1_oe_n, b2_oe_n}), 32'h3f);
    axi_rd(PCF_CTRL_OFFS);
    check(rd, 32'(PCF_CTRL_RESET));
    // Unmapped words answer with an error and read as zero
    for (int i = 2; i < 4; i++)
    begin
      axi_rd(4'(i * 4));
      check({rd[29:0], rs}, {30'h0, PCF_RESP_SLVERR});
      axi_wr(4'(i * 4), $urandom(), 4'hf);
      check(32'(rs), 32'(PCF_RESP_SLVERR));
    end
    axi_wr(PCF_STATUS_OFFS, 32'hffffffff, 4'hf);
    check(32'(rs), 32'(PCF_RESP_OKAY));
    axi_wr(PCF_CTRL_OFFS, 32'h0, 4'he);
    axi_rd(PCF_CTRL_OFFS);
    check(rd, 32'(PCF_CTRL_RESET));
    wait_lock();
    // Enable drivers with bypass held low
    set_ctrl(4'h0);
    axi_rd(PCF_STATUS_OFFS);
    check(rd, 32'h6);
    check(32'({b1_oe_n, b2_oe_n}), 32'h0);
    wait_lock();
    for (int i = 0; i < 6; i++)
    begin
      sel = (i < 2) ? i[0] : 1'($urandom());
      set_ctrl({2'b00, sel, 1'b0});
      wait_lock();
      measure(1'b0);
      check(32'(hi), 32'(exp_half(1'b0, sel, 1'b0)));
      check(32'(lo), 32'(hi));
      measure(1'b1);
      check(32'(hi), 32'(exp_half(1'b0, sel, 1'b1)));
      check(32'(lo), 32'(hi));
    end
    for (int i = 0; i < 2; i++)
    begin
      set_ctrl({2'b01, i[0], 1'b0});
      repeat (30) @(posedge clk);
      measure(1'b0);
      check(32'(hi), 32'(exp_half(1'b1, i[0], 1'b0)));
      measure(1'b1);
      check(32'(hi), 32'(exp_half(1'b1, i[0], 1'b1)));
      check(32'(lo), 32'(hi));
      check(32'({b1_oe_n, b2_oe_n}), 32'h0);
    end
    // Clear in test mode parks every output low
    set_ctrl(4'hc);
    repeat (4) @(posedge clk);
    el = 0;
    repeat (3 * REF_CLKS)
    begin
      @(posedge clk);
      el = el | 32'({b1, b2});
    end
    check(32'(el), 32'h0);
    set_ctrl(4'h8);
    wait_lock();
    measure(1'b1);
    check(32'(hi), 32'(VDIV));
    set_ctrl(4'h1);
    repeat (3) @(posedge clk);
    check(32'({b1_oe_n, b2_oe_n}), 32'h3f);
    // Losing the reference drops lock until it returns and settles again
    ref_run <= 1'b0;
    repeat (100) @(posedge clk);
    axi_rd(PCF_STATUS_OFFS);
    check(rd, 32'h0);
    ref_run <= 1'b1;
    wait_lock();
    // Reset in mid-run parks every pin and drops lock at once
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(32'({b1_oe_n, b2_oe_n, b1, b2}), 32'hfc0);
    axi_rd(PCF_STATUS_OFFS);
    check(rd, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
